// >>> bench/subtract_xor_swap_sleep_exec_bench.sv
/* Self-checking bench for the execution block: each scenario preloads
   state over AXI4-Lite, issues a command and reads the outcome back.
   Assumes the register map and opcodes of alu_exec_pkg. */
module subtract_xor_swap_sleep_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_val;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] port_a_direction, port_b_direction, port_c_direction;
    int mismatches, cmp_count, i;
    // Design under test, default prescaler width
    subtract_xor_swap_sleep_exec subtract_xor_swap_sleep_exec_inst (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
        .port_c_direction(port_c_direction));
    // 50 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Verdict and end of run
    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("MISMATCH %0t %s", $time, msg);
            mismatches++;
        end
    endtask
    // Bounded wait ran out
    task automatic hang(input int n);
        if (n == 50)
        begin
            mismatches++;
            finish_test();
        end
    endtask
    // One write; each half released on its own handshake
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        resp = bresp;
        bready <= 1'b0;
        hang(n);
    endtask
    // One read; data taken at the rvalid edge
    task automatic rd(input logic [11:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rd_val = rdata;
        resp = rresp;
        rready <= 1'b0;
        hang(n);
    endtask
    // Issue one instruction word
    task automatic cmd(input logic [3:0] op, input logic [6:0] f, input logic d, input logic [7:0] k);
        wr(alu_exec_pkg::off_cmd, {8'h00, k, 4'h0, d, f, op});
    endtask
    // Preload accumulator, file register f and status
    task automatic put(input logic [7:0] acc, input logic [6:0] f, input logic [7:0] fv, input logic [7:0] st);
        wr(alu_exec_pkg::off_acc, {24'h0, acc});
        wr(alu_exec_pkg::off_file + {3'h0, f, 2'h0}, {24'h0, fv});
        wr(alu_exec_pkg::off_status, {24'h0, st});
    endtask
    // Read back the same three places; status masked to its five flags
    task automatic see(input logic [7:0] acc, input logic [6:0] f, input logic [7:0] fv, input logic [7:0] st);
        rd(alu_exec_pkg::off_acc);
        chk(rd_val, {24'h0, acc}, "accumulator");
        rd(alu_exec_pkg::off_file + {3'h0, f, 2'h0});
        chk(rd_val, {24'h0, fv}, "file register");
        rd(alu_exec_pkg::off_status);
        chk({27'h0, rd_val[4:0]}, {27'h0, st[4:0]}, "status flags");
    endtask
    // Subtractions: equal operands, f at 127, literal 255, borrow in and out
    task automatic t_sub();
        put(8'h35, 7'd10, 8'h35, 8'h18);
        cmd(alu_exec_pkg::op_sub_acc_from_reg, 7'd10, 1'b1, 8'h00);
        see(8'h35, 7'd10, 8'h00, 8'h1f);
        put(8'h36, 7'd127, 8'h35, 8'h1f);
        cmd(alu_exec_pkg::op_sub_acc_from_reg, 7'd127, 1'b0, 8'h00);
        see(8'hff, 7'd127, 8'h35, 8'h18);
        put(8'h0f, 7'd0, 8'h00, 8'h18);
        cmd(alu_exec_pkg::op_sub_acc_from_literal, 7'd0, 1'b0, 8'h10);
        see(8'h01, 7'd0, 8'h00, 8'h19);
        put(8'hff, 7'd0, 8'h00, 8'h18);
        cmd(alu_exec_pkg::op_sub_acc_from_literal, 7'd0, 1'b0, 8'hff);
        see(8'h00, 7'd0, 8'h00, 8'h1f);
        put(8'h0f, 7'd20, 8'h10, 8'h18);
        cmd(alu_exec_pkg::op_sub_with_borrow, 7'd20, 1'b0, 8'h00);
        see(8'h00, 7'd20, 8'h10, 8'h1d);
        put(8'h01, 7'd20, 8'h10, 8'h19);
        cmd(alu_exec_pkg::op_sub_with_borrow, 7'd20, 1'b1, 8'h00);
        see(8'h01, 7'd20, 8'h0f, 8'h19);
    endtask
    // Swap, xor and rotate; flags outside each set must hold
    task automatic t_logic();
        put(8'h00, 7'd30, 8'ha5, 8'h07);
        cmd(alu_exec_pkg::op_nibble_swap, 7'd30, 1'b1, 8'h00);
        cmd(alu_exec_pkg::op_nibble_swap, 7'd30, 1'b0, 8'h00);
        see(8'ha5, 7'd30, 8'h5a, 8'h07);
        put(8'h5a, 7'd40, 8'h3c, 8'h03);
        cmd(alu_exec_pkg::op_xor_literal_acc, 7'd0, 1'b0, 8'h5a);
        see(8'h00, 7'd40, 8'h3c, 8'h07);
        cmd(alu_exec_pkg::op_xor_acc_reg, 7'd40, 1'b0, 8'h00);
        see(8'h3c, 7'd40, 8'h3c, 8'h03);
        cmd(alu_exec_pkg::op_xor_acc_reg, 7'd40, 1'b1, 8'h00);
        see(8'h3c, 7'd40, 8'h00, 8'h07);
        // Zero result but zero flag left alone by the rotate
        put(8'h77, 7'd50, 8'h01, 8'h02);
        cmd(alu_exec_pkg::op_rotate_right_thru_carry, 7'd50, 1'b0, 8'h00);
        cmd(alu_exec_pkg::op_rotate_right_thru_carry, 7'd50, 1'b1, 8'h00);
        see(8'h00, 7'd50, 8'h80, 8'h03);
    endtask
    // Direction loads for selectors 4..7, then sleep and an unmapped place
    task automatic t_dir_sleep();
        wr(alu_exec_pkg::off_status, 32'h15);
        for (i = 4; i < 8; i++)
        begin
            wr(alu_exec_pkg::off_acc, 32'h20 + i);
            cmd(alu_exec_pkg::op_load_port_direction, 7'(i), 1'b0, 8'h00);
        end
        chk({port_a_direction, port_b_direction, port_c_direction}, 32'h252627, "direction pins");
        see(8'h27, 7'd0, 8'h00, 8'h15);
        // Let the prescaler wrap so that sleep has a count to clear
        repeat (300) @(posedge aclk);
        rd(alu_exec_pkg::off_wdog);
        chk({31'h0, rd_val[7:0] != 8'h00}, 32'h1, "watchdog idle");
        wr(alu_exec_pkg::off_status, 32'h0f);
        cmd(alu_exec_pkg::op_sleep, 7'd0, 1'b0, 8'h00);
        rd(alu_exec_pkg::off_wdog);
        chk({24'h0, rd_val[7:0]}, 32'h0, "watchdog count");
        chk({31'h0, rd_val[15:8] < 8'h10}, 32'h1, "watchdog prescaler");
        rd(alu_exec_pkg::off_status);
        chk({27'h0, rd_val[4:0]}, 32'h17, "sleep flags");
        wr(12'h100, 32'hff);
        chk({30'h0, resp}, {30'h0, alu_exec_pkg::resp_decerr}, "unmapped write");
        rd(12'h100);
        chk({rd_val[29:0], resp}, {30'h0, alu_exec_pkg::resp_decerr}, "unmapped read");
        // Lane 0 off: write ignored; unknown opcode leaves accumulator, file and flags alone
        wstrb <= 4'he;
        wr(alu_exec_pkg::off_acc, 32'h99);
        chk({30'h0, resp}, {30'h0, alu_exec_pkg::resp_okay}, "masked write response");
        wstrb <= 4'hf;
        cmd(4'h0, 7'd0, 1'b0, 8'h00);
        see(8'h27, 7'd0, 8'h00, 8'h17);
    endtask
    // Main sequence
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        mismatches = 0;
        cmp_count = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        wr(alu_exec_pkg::off_file, 32'h0);   // File registers have no reset value
        see(8'h00, 7'd0, 8'h00, 8'h18);
        t_sub();
        t_logic();
        t_dir_sleep();
        finish_test();
    end
endmodule

// >>> logic/alu_exec_pkg.sv
/*
 * Constants for the subtract/xor/swap/sleep execution block: register
 * offsets on the AXI4-Lite map, command field layout, opcodes, flag
 * positions and reset values.
 * Assumes a 32-bit AXI4-Lite master and byte addresses that are word aligned.
 */
package alu_exec_pkg;
    // Register byte offsets
    localparam logic [11:0] off_cmd = 12'h000;      // Issue one instruction
    localparam logic [11:0] off_acc = 12'h004;      // Accumulator
    localparam logic [11:0] off_status = 12'h008;   // Flags
    localparam logic [11:0] off_wdog = 12'h00c;     // Watchdog count and prescaler
    localparam logic [11:0] off_dir_a = 12'h010;    // Port A direction
    localparam logic [11:0] off_dir_b = 12'h014;    // Port B direction
    localparam logic [11:0] off_dir_c = 12'h018;    // Port C direction
    localparam logic [11:0] off_file = 12'h200;     // File register window base
    localparam logic [11:0] file_mask = 12'he00;    // Bits that select the window
    // Command word fields
    localparam int cmd_op_lsb = 0;       // Opcode, 4 bits
    localparam int cmd_f_lsb = 4;        // File address, 7 bits
    localparam int cmd_d_bit = 11;       // Destination bit
    localparam int cmd_k_lsb = 16;       // Literal, 8 bits
    // Opcodes
    localparam logic [3:0] op_rotate_right_thru_carry = 4'h1;
    localparam logic [3:0] op_sub_acc_from_reg = 4'h2;
    localparam logic [3:0] op_sub_acc_from_literal = 4'h3;
    localparam logic [3:0] op_sub_with_borrow = 4'h4;
    localparam logic [3:0] op_nibble_swap = 4'h5;
    localparam logic [3:0] op_load_port_direction = 4'h6;
    localparam logic [3:0] op_xor_literal_acc = 4'h7;
    localparam logic [3:0] op_xor_acc_reg = 4'h8;
    localparam logic [3:0] op_sleep = 4'h9;
    // Direction register selectors for the load instruction
    localparam logic [6:0] sel_port_a = 7'h05;
    localparam logic [6:0] sel_port_b = 7'h06;
    localparam logic [6:0] sel_port_c = 7'h07;
    // Status bit positions
    localparam int st_carry = 0;
    localparam int st_nibble = 1;
    localparam int st_zero = 2;
    localparam int st_powerdown = 3;
    localparam int st_timeout = 4;
    // Reset value, zero byte and bus response codes
    localparam logic [7:0] dir_reset = 8'hff;       // All pins input
    localparam logic [7:0] byte_zero = 8'h00;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_decerr = 2'h3;
endpackage

// >>> logic/subtract_xor_swap_sleep_exec.sv
/*
 * Execution datapath for rotate, subtract, swap, xor, port direction load
 * and sleep, reached over an AXI4-Lite slave. A write to the command
 * register with byte lane 0 strobed executes one instruction in the cycle
 * the write completes.
 * Assumes a single clock aclk, synchronous active-low aresetn, and an
 * AXI4-Lite master that keeps to the valid/ready rules.
 */
module subtract_xor_swap_sleep_exec #(
    parameter int presc_w = 8,         // Watchdog prescaler width
    parameter int file_depth = 128     // File registers reachable by f
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [7:0] port_a_direction,
    output logic [7:0] port_b_direction,
    output logic [7:0] port_c_direction
);
    typedef struct packed {    // Module state except the file registers in one record
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [11:0] waddr;
        logic [31:0] wdat;
        logic [3:0] wstb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] acc;
        logic carry;
        logic nibble_carry_flag;
        logic zero;
        logic powerdown_status_flag;
        logic timeout_status_flag;
        logic [7:0] watchdog_counter;
        logic [presc_w-1:0] presc;
        logic [7:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0] dir_c;
        logic [31:0] last_cmd;
    } state_t;
    state_t st;          // Registered state
    state_t next_st;     // Next value
    logic [7:0] file_mem [file_depth];   // File registers; no reset, software initialises them
    logic mem_we;                    // File write strobe
    logic [6:0] mem_waddr;           // File write address
    logic [7:0] mem_wdata;           // File write data
    // Decoded command, valid in the write-complete cycle
    logic wr_fire;                   // Both halves held, response free
    logic exec;                      // Command register write executes
    logic [3:0] op;                  // Opcode
    logic [6:0] fsel;                // File address
    logic dbit;                      // Destination bit
    logic [7:0] lit;                 // Literal
    logic [7:0] fval;                // Operand read from file
    logic [7:0] sub_a;               // Minuend of subtraction
    logic sub_cin;                   // Inverted borrow in
    logic [8:0] sub_sum;             // Full subtraction with carry out
    logic [4:0] sub_low;             // Low nibble subtraction
    logic [7:0] res;                 // Result for destination
    logic to_file;                   // Result goes back to file
    assign wr_fire = st.aw_held && st.w_held && !st.bvalid;
    assign exec = wr_fire && st.waddr == alu_exec_pkg::off_cmd && st.wstb[0];
    assign op = st.wdat[alu_exec_pkg::cmd_op_lsb +: 4];
    assign fsel = st.wdat[alu_exec_pkg::cmd_f_lsb +: 7];
    assign dbit = st.wdat[alu_exec_pkg::cmd_d_bit];
    assign lit = st.wdat[alu_exec_pkg::cmd_k_lsb +: 8];
    assign fval = file_mem[fsel];
    // Subtraction by adding the inverted accumulator; carry out is the inverted borrow
    always_comb
    begin
        sub_a = (op == alu_exec_pkg::op_sub_acc_from_literal) ? lit : fval;
        sub_cin = (op == alu_exec_pkg::op_sub_with_borrow) ? st.carry : 1'b1;
        sub_sum = {1'b0, sub_a} + {1'b0, ~st.acc} + {8'h00, sub_cin};
        sub_low = {1'b0, sub_a[3:0]} + {1'b0, ~st.acc[3:0]} + {4'h0, sub_cin};
    end
    // Read-side register mux
    function automatic logic [31:0] read_word(input state_t s, input logic [11:0] a, input logic [7:0] fdat);
        logic [31:0] v;
        v = 32'h0000_0000;
        if ((a & alu_exec_pkg::file_mask) == alu_exec_pkg::off_file)
            v = {24'h00_0000, fdat};
        else if (a == alu_exec_pkg::off_cmd)
            v = s.last_cmd;
        else if (a == alu_exec_pkg::off_acc)
            v = {24'h00_0000, s.acc};
        else if (a == alu_exec_pkg::off_status)
        begin
            v[alu_exec_pkg::st_carry] = s.carry;
            v[alu_exec_pkg::st_nibble] = s.nibble_carry_flag;
            v[alu_exec_pkg::st_zero] = s.zero;
            v[alu_exec_pkg::st_powerdown] = s.powerdown_status_flag;
            v[alu_exec_pkg::st_timeout] = s.timeout_status_flag;
        end
        else if (a == alu_exec_pkg::off_wdog)
            v = {16'h0000, 8'(s.presc), s.watchdog_counter};
        else if (a == alu_exec_pkg::off_dir_a)
            v = {24'h00_0000, s.dir_a};
        else if (a == alu_exec_pkg::off_dir_b)
            v = {24'h00_0000, s.dir_b};
        else if (a == alu_exec_pkg::off_dir_c)
            v = {24'h00_0000, s.dir_c};
        return v;
    endfunction
    // Address is mapped when it hits a register or the file window
    function automatic logic mapped(input logic [11:0] a);
        return ((a & alu_exec_pkg::file_mask) == alu_exec_pkg::off_file) || a == alu_exec_pkg::off_cmd
            || a == alu_exec_pkg::off_acc || a == alu_exec_pkg::off_status || a == alu_exec_pkg::off_wdog
            || a == alu_exec_pkg::off_dir_a || a == alu_exec_pkg::off_dir_b || a == alu_exec_pkg::off_dir_c;
    endfunction
    // Next state: bus handshakes, execution, watchdog
    always_comb
    begin
        next_st = st;
        mem_we = 1'b0;
        mem_waddr = fsel;
        mem_wdata = 8'h00;
        res = 8'h00;
        to_file = 1'b0;
        next_st.presc = st.presc + 1'b1;     // Watchdog free runs; prescaler wrap advances the counter
        if (&st.presc)
            next_st.watchdog_counter = st.watchdog_counter + 8'h01;
        if (awvalid && st.awready)           // Write address and data taken in either order
        begin
            next_st.aw_held = 1'b1;
            next_st.awready = 1'b0;
            next_st.waddr = awaddr;
        end
        if (wvalid && st.wready)
        begin
            next_st.w_held = 1'b1;
            next_st.wready = 1'b0;
            next_st.wdat = wdata;
            next_st.wstb = wstrb;
        end
        if (st.bvalid && bready)             // Response released; reopen both channels
        begin
            next_st.bvalid = 1'b0;
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end
        if (wr_fire)                         // Complete the write
        begin
            next_st.bvalid = 1'b1;
            next_st.bresp = mapped(st.waddr) ? alu_exec_pkg::resp_okay : alu_exec_pkg::resp_decerr;
            if (st.wstb[0])                  // Lane 0 strobe gates every write; data above lane 0 is used by the command word only
            begin
                if ((st.waddr & alu_exec_pkg::file_mask) == alu_exec_pkg::off_file)
                begin
                    mem_we = 1'b1;
                    mem_waddr = st.waddr[8:2];
                    mem_wdata = st.wdat[7:0];
                end
                else if (st.waddr == alu_exec_pkg::off_acc)
                    next_st.acc = st.wdat[7:0];
                else if (st.waddr == alu_exec_pkg::off_status)
                begin
                    next_st.carry = st.wdat[alu_exec_pkg::st_carry];
                    next_st.nibble_carry_flag = st.wdat[alu_exec_pkg::st_nibble];
                    next_st.zero = st.wdat[alu_exec_pkg::st_zero];
                    next_st.powerdown_status_flag = st.wdat[alu_exec_pkg::st_powerdown];
                    next_st.timeout_status_flag = st.wdat[alu_exec_pkg::st_timeout];
                end
                else if (st.waddr == alu_exec_pkg::off_dir_a)
                    next_st.dir_a = st.wdat[7:0];
                else if (st.waddr == alu_exec_pkg::off_dir_b)
                    next_st.dir_b = st.wdat[7:0];
                else if (st.waddr == alu_exec_pkg::off_dir_c)
                    next_st.dir_c = st.wdat[7:0];
            end
        end
        if (exec)                            // Execute one instruction
        begin
            next_st.last_cmd = st.wdat;
            case (op)
                alu_exec_pkg::op_rotate_right_thru_carry:
                begin
                    res = {st.carry, fval[7:1]};
                    next_st.carry = fval[0];
                    to_file = dbit;
                end
                alu_exec_pkg::op_sub_acc_from_reg, alu_exec_pkg::op_sub_with_borrow:
                begin
                    res = sub_sum[7:0];
                    next_st.carry = sub_sum[8];
                    next_st.nibble_carry_flag = sub_low[4];
                    next_st.zero = (sub_sum[7:0] == alu_exec_pkg::byte_zero);
                    to_file = dbit;
                end
                alu_exec_pkg::op_sub_acc_from_literal:
                begin
                    res = sub_sum[7:0];
                    next_st.carry = sub_sum[8];
                    next_st.nibble_carry_flag = sub_low[4];
                    next_st.zero = (sub_sum[7:0] == alu_exec_pkg::byte_zero);
                end
                alu_exec_pkg::op_nibble_swap:
                begin
                    res = {fval[3:0], fval[7:4]};
                    to_file = dbit;
                end
                alu_exec_pkg::op_load_port_direction:
                begin
                    res = st.acc;
                    if (fsel == alu_exec_pkg::sel_port_a)    // Selectors outside 5..7 load nothing
                        next_st.dir_a = st.acc;
                    else if (fsel == alu_exec_pkg::sel_port_b)
                        next_st.dir_b = st.acc;
                    else if (fsel == alu_exec_pkg::sel_port_c)
                        next_st.dir_c = st.acc;
                end
                alu_exec_pkg::op_xor_literal_acc:
                begin
                    res = st.acc ^ lit;
                    next_st.zero = ((st.acc ^ lit) == alu_exec_pkg::byte_zero);
                end
                alu_exec_pkg::op_xor_acc_reg:
                begin
                    res = st.acc ^ fval;
                    next_st.zero = ((st.acc ^ fval) == alu_exec_pkg::byte_zero);
                    to_file = dbit;
                end
                alu_exec_pkg::op_sleep:
                begin
                    res = st.acc;
                    next_st.watchdog_counter = alu_exec_pkg::byte_zero;
                    next_st.presc = '0;
                    next_st.powerdown_status_flag = 1'b0;
                    next_st.timeout_status_flag = 1'b1;
                end
                default:
                    res = st.acc;   // Unknown opcodes only record the command word in last_cmd
            endcase
            if (to_file)                     // Route result; load and sleep leave the accumulator as is
            begin
                mem_we = 1'b1;
                mem_waddr = fsel;
                mem_wdata = res;
            end
            else
                next_st.acc = res;
        end
        if (st.rvalid && rready)             // Read channel: one outstanding read, answer one cycle after address
        begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
        if (arvalid && st.arready)
        begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rdata = read_word(st, araddr, file_mem[araddr[8:2]]);
            next_st.rresp = mapped(araddr) ? alu_exec_pkg::resp_okay : alu_exec_pkg::resp_decerr;
        end
    end
    // State register with synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.powerdown_status_flag <= 1'b1;
            st.timeout_status_flag <= 1'b1;
            st.dir_a <= alu_exec_pkg::dir_reset;
            st.dir_b <= alu_exec_pkg::dir_reset;
            st.dir_c <= alu_exec_pkg::dir_reset;
        end
        else
            st <= next_st;
    end
    // File memory write port
    always_ff @(posedge aclk)
    begin
        if (mem_we)
            file_mem[mem_waddr] <= mem_wdata;
    end
    // Outputs straight from state flops
    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign port_a_direction = st.dir_a;
    assign port_b_direction = st.dir_b;
    assign port_c_direction = st.dir_c;
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_sleep;
        exec && op == alu_exec_pkg::op_sleep;
    endsequence
    sequence s_sub_plain;
        exec && (op == alu_exec_pkg::op_sub_acc_from_reg || op == alu_exec_pkg::op_sub_acc_from_literal);
    endsequence
    a_sleep_wdog_clear: assert property (s_sleep |=> st.watchdog_counter == 8'h00 && st.presc == '0)
        else $error("watchdog not cleared by sleep");
    a_sleep_flags: assert property (s_sleep |=> !st.powerdown_status_flag && st.timeout_status_flag
        && $stable(st.carry) && $stable(st.zero) && $stable(st.nibble_carry_flag))
        else $error("sleep flags wrong");
    a_sub_carry_dir: assert property (s_sub_plain |=> st.carry == ($past(sub_a) >= $past(st.acc)))
        else $error("subtract carry wrong");
    a_sub_nibble_dir: assert property (s_sub_plain |=>
        st.nibble_carry_flag == ($past(sub_a[3:0]) >= $past(st.acc[3:0])))
        else $error("subtract nibble carry wrong");
    a_borrow_result: assert property (exec && op == alu_exec_pkg::op_sub_with_borrow && !dbit |=>
        st.acc == 8'($past(fval) - $past(st.acc) - {7'h00, !$past(st.carry)}))
        else $error("borrow subtract result wrong");
    a_swap_acc: assert property (exec && op == alu_exec_pkg::op_nibble_swap && !dbit |=>
        st.acc == {$past(fval[3:0]), $past(fval[7:4])} && $stable(st.zero))
        else $error("nibble swap wrong");
    a_dir_load_a: assert property (exec && op == alu_exec_pkg::op_load_port_direction
        && fsel == alu_exec_pkg::sel_port_a |=> port_a_direction == $past(st.acc) && $stable(st.carry))
        else $error("port direction load wrong");
    a_xor_lit_zero: assert property (exec && op == alu_exec_pkg::op_xor_literal_acc |=>
        st.zero == (st.acc == 8'h00) && $stable(st.carry) && $stable(st.nibble_carry_flag))
        else $error("literal xor flags wrong");
    a_xor_reg_dest: assert property (exec && op == alu_exec_pkg::op_xor_acc_reg && dbit |=>
        $stable(st.acc) ##0 file_mem[$past(fsel)] == ($past(st.acc) ^ $past(fval)))
        else $error("register xor destination wrong");
    a_rotate_carry: assert property (exec && op == alu_exec_pkg::op_rotate_right_thru_carry && !dbit |=>
        st.carry == $past(fval[0]) && st.acc[7] == $past(st.carry) && $stable(st.zero))
        else $error("rotate through carry wrong");
    a_bus_answer: assert property (wr_fire |=> bvalid [*1] ##0 !awready && !wready)
        else $error("write response not raised");
endmodule
